// ===== hdl/slea_core.sv
// Effective address generation, stack checking and secure RAM gating
//
// Operation
// RQ1 - Stack pointer names next free word, grows up
// RQ2 - Pop predecrements, push postincrements
// RQ3 - Call push clears counter high byte
// RQ4 - Exception push joins status byte, counter high
// RQ5 - Limit has no reset value, bit0 zero
// RQ6 - Stack pointer addresses compared to limit; code compares only push addresses, not pop or indirect ones
// RQ7 - Push at limit passes, next one traps
// RQ8 - Stack pointer below floor raises underflow
// RQ9 - Software avoids pointer read after limit write
// RQ10 - Boot secure RAM only for boot code
// RQ11 - Secure RAM only for secure code
// RQ12 - File direct address from 13-bit field
// RQ13 - File ops imply register zero, chosen writeback
// RQ14 - Three operand: register, memory or literal
// RQ15 - Indirect with post and pre modify
// RQ16 - Indexed and literal offset sums
// RQ17 - Move shares one 4-bit offset field
// RQ18 - Literal widths 5/10 general, 8/16 move
// RQ19 - Branch signed 16, disable unsigned 14
// RQ20 - Move reaches whole data space
// RQ21 - Stack error is one-cycle trap request
`timescale 1ns/10ps
`default_nettype none
module slea_core (
  input wire logic CLK,
  input wire logic RST,
  input wire logic REQ_VALID,
  input wire slea_pkg::slea_mode_t MODE,
  input wire logic IS_MOVE,
  input wire logic DEST_TO_DEFAULT_WORKING_REG,
  input wire logic [slea_pkg::REG_IDX_W-1:0] PTR_IDX,
  input wire logic [slea_pkg::REG_IDX_W-1:0] OFS_IDX,
  input wire logic [slea_pkg::FILE_ADDR_W-1:0] FILE_ADDR,
  input wire logic [slea_pkg::WORD_W-1:0] FULL_ADDR,
  input wire logic [slea_pkg::WORD_W-1:0] MOD_CONST,
  input wire logic [slea_pkg::WORD_W-1:0] LIT_OFS,
  input wire logic [slea_pkg::WORD_W-1:0] PC_LOW,
  input wire logic [7:0] PC_HIGH,
  input wire logic [7:0] STATUS_LOW,
  input wire logic LIT_VALID,
  input wire slea_pkg::slea_lit_t LIT_KIND,
  input wire logic [slea_pkg::WORD_W-1:0] LIT_FIELD,
  input wire logic LIMIT_WR,
  input wire logic [slea_pkg::WORD_W-1:0] LIMIT_DATA,
  input wire logic REG_WR,
  input wire logic [slea_pkg::REG_IDX_W-1:0] REG_WR_IDX,
  input wire logic [slea_pkg::WORD_W-1:0] REG_WR_DATA,
  input wire slea_pkg::slea_seg_t EXEC_SEG,
  input wire logic BOOT_RAM_EN,
  input wire logic [slea_pkg::WORD_W-1:0] BOOT_RAM_LO,
  input wire logic [slea_pkg::WORD_W-1:0] BOOT_RAM_HI,
  input wire logic SEC_RAM_EN,
  input wire logic [slea_pkg::WORD_W-1:0] SEC_RAM_LO,
  input wire logic [slea_pkg::WORD_W-1:0] SEC_RAM_HI,
  output logic EA_VALID,
  output logic [slea_pkg::WORD_W-1:0] EA,
  output logic [slea_pkg::WORD_W-1:0] PUSH_DATA,
  output logic PUSH_DATA_VALID,
  output logic [slea_pkg::REG_IDX_W-1:0] WB_IDX,
  output logic ACCESS_BLOCKED,
  output logic STACK_TRAP,
  output logic STACK_UNDERFLOW,
  output logic [slea_pkg::WORD_W-1:0] LIT_VALUE,
  output logic [slea_pkg::WORD_W-1:0] SP_OUT,
  output logic [slea_pkg::WORD_W-1:0] LIMIT_OUT
);
  import slea_pkg::*;
  logic [WORD_W-1:0] limit_q;
  logic [WORD_W-1:0] ptr_val;
  logic [WORD_W-1:0] ofs_val;
  logic [WORD_W-1:0] sp_val;
  logic [WORD_W-1:0] ea_d;
  logic ptr_wr_d;
  logic [WORD_W-1:0] ptr_new_d;
  logic uses_sp;
  logic is_push;
  logic over_d;
  logic under_d;
  logic blocked_d;
  logic [WORD_W-1:0] push_d;
  logic [WORD_W-1:0] lit_d;
  logic [REG_IDX_W-1:0] wb_idx_d;
  logic in_boot_d;
  logic in_sec_d;

  // Registered ports kept for later pipelining; address math uses live values
  // Pointer writes follow the decoded index, so push and pop move the stack reg
  slea_regfile slea_regfile_inst (
    .clk(CLK),
    .rst(RST),
    .ra_idx(PTR_IDX),
    .rb_idx(OFS_IDX),
    .ra_data(),
    .rb_data(),
    .sp_data(sp_val),
    .wa_en(REG_WR),
    .wa_idx(REG_WR_IDX),
    .wa_data(REG_WR_DATA),
    .wb_en(ptr_wr_d),
    .wb_idx(wb_idx_d),
    .wb_data(ptr_new_d)
  );

  // Live copies; pointer updates take effect on the next edge
  always_comb begin
    ptr_val = slea_regfile_inst.mem_q[PTR_IDX];
    ofs_val = slea_regfile_inst.mem_q[OFS_IDX];
  end

  // Limit is left unreset on purpose; bit 0 always forced clear
  always_ff @(posedge CLK) begin
    if (LIMIT_WR) begin
      limit_q <= {LIMIT_DATA[WORD_W-1:1], 1'b0}; // RQ5
    end
  end

  always_comb begin
    ea_d = ptr_val;
    ptr_wr_d = 1'b0;
    ptr_new_d = ptr_val;
    wb_idx_d = PTR_IDX;
    is_push = 1'b0;
    uses_sp = (PTR_IDX == REG_IDX_W'(SP_IDX));
    case (MODE)
      SLEA_AM_FILE: begin
        ea_d = IS_MOVE ? FULL_ADDR : {{(WORD_W-FILE_ADDR_W){1'b0}}, FILE_ADDR}; // RQ12 RQ20
        uses_sp = 1'b0;
        wb_idx_d = DEST_TO_DEFAULT_WORKING_REG ? REG_IDX_W'(DEFAULT_WORKING_REG_IDX) : PTR_IDX; // RQ13
      end
      SLEA_AM_DIRECT: begin
        ea_d = ptr_val; // RQ14
        uses_sp = 1'b0;
      end
      SLEA_AM_IND: begin
        ea_d = ptr_val; // RQ15
      end
      SLEA_AM_IND_POST: begin
        ea_d = ptr_val; // RQ15
        ptr_wr_d = REQ_VALID;
        ptr_new_d = ptr_val + MOD_CONST;
      end
      SLEA_AM_IND_PRE: begin
        ea_d = ptr_val + MOD_CONST; // RQ15
        ptr_wr_d = REQ_VALID;
        ptr_new_d = ea_d;
      end
      SLEA_AM_INDEXED: begin
        ea_d = ptr_val + ofs_val; // RQ16 RQ17
      end
      SLEA_AM_LIT_OFS: begin
        ea_d = ptr_val + LIT_OFS; // RQ16
      end
      SLEA_AM_POP: begin
        ea_d = sp_val - WORD_STEP; // RQ2
        uses_sp = 1'b1;
        ptr_wr_d = REQ_VALID;
        ptr_new_d = ea_d;
        wb_idx_d = REG_IDX_W'(SP_IDX);
      end
      SLEA_AM_PUSH, SLEA_AM_CALL_PUSH, SLEA_AM_EXC_PUSH: begin
        ea_d = sp_val; // RQ1 RQ2
        uses_sp = 1'b1;
        is_push = 1'b1;
        ptr_wr_d = REQ_VALID;
        ptr_new_d = sp_val + WORD_STEP;
        wb_idx_d = REG_IDX_W'(SP_IDX);
      end
      default: begin
        ea_d = ptr_val;
      end
    endcase
  end

  // Pushed word depends on who pushes the counter
  always_comb begin
    case (MODE)
      SLEA_AM_CALL_PUSH: begin
        push_d = {8'h00, PC_HIGH}; // RQ3
      end
      SLEA_AM_EXC_PUSH: begin
        push_d = {STATUS_LOW, PC_HIGH}; // RQ4
      end
      default: begin
        push_d = PC_LOW;
      end
    endcase
  end

  // Push at limit allowed; only address past limit trips this overflow check
  always_comb begin
    over_d = REQ_VALID && uses_sp && is_push && (ea_d > limit_q); // RQ6 RQ7
  end

  // Floor check covers any stack-pointer address, not only push and pop
  always_comb begin
    under_d = REQ_VALID && uses_sp && (ea_d < SP_FLOOR); // RQ8
  end

  // Inclusive window compares, one per protected segment
  always_comb begin
    in_boot_d = 1'b0;
    if (BOOT_RAM_EN) begin
      in_boot_d = (ea_d >= BOOT_RAM_LO) && (ea_d <= BOOT_RAM_HI);
    end
  end

  always_comb begin
    in_sec_d = 1'b0;
    if (SEC_RAM_EN) begin
      in_sec_d = (ea_d >= SEC_RAM_LO) && (ea_d <= SEC_RAM_HI);
    end
  end

  // Windows may overlap; either owner check can refuse the access
  always_comb begin
    blocked_d = 1'b0;
    if (in_boot_d && EXEC_SEG != SLEA_SEG_BOOT) begin
      blocked_d = 1'b1; // RQ10
    end
    if (in_sec_d && EXEC_SEG != SLEA_SEG_SECURE) begin
      blocked_d = 1'b1; // RQ11
    end
  end

  always_comb begin
    case (LIT_KIND)
      SLEA_LIT_5: lit_d = {{(WORD_W-LIT5_W){1'b0}}, LIT_FIELD[LIT5_W-1:0]}; // RQ14 RQ18
      SLEA_LIT_8: lit_d = {{(WORD_W-LIT8_W){1'b0}}, LIT_FIELD[LIT8_W-1:0]}; // RQ18
      SLEA_LIT_10: lit_d = {{(WORD_W-LIT10_W){1'b0}}, LIT_FIELD[LIT10_W-1:0]}; // RQ18
      SLEA_LIT_14: lit_d = {{(WORD_W-LIT14_W){1'b0}}, LIT_FIELD[LIT14_W-1:0]}; // RQ19
      SLEA_LIT_16S: lit_d = LIT_FIELD; // RQ19
      default: lit_d = LIT_FIELD;
    endcase
  end

  // Handshake outputs; a refused access shows blocked instead of valid
  always_ff @(posedge CLK) begin
    if (RST) begin
      EA_VALID <= 1'b0;
      ACCESS_BLOCKED <= 1'b0;
    end else begin
      EA_VALID <= REQ_VALID && !blocked_d;
      ACCESS_BLOCKED <= REQ_VALID && blocked_d;
    end
  end

  // Address and writeback index stand until the next edge
  always_ff @(posedge CLK) begin
    if (RST) begin
      EA <= REG_RESET;
    end else begin
      EA <= ea_d;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      WB_IDX <= '0;
    end else begin
      WB_IDX <= wb_idx_d;
    end
  end

  // Trap pulses one cycle after the request edge, aligned with the address
  always_ff @(posedge CLK) begin
    if (RST) begin
      STACK_TRAP <= 1'b0;
    end else begin
      STACK_TRAP <= over_d || under_d; // RQ21
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      STACK_UNDERFLOW <= 1'b0;
    end else begin
      STACK_UNDERFLOW <= under_d; // RQ8
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      PUSH_DATA <= REG_RESET;
      PUSH_DATA_VALID <= 1'b0;
    end else begin
      PUSH_DATA <= push_d;
      PUSH_DATA_VALID <= REQ_VALID && is_push;
    end
  end

  // Literal value holds until the next decode strobe
  always_ff @(posedge CLK) begin
    if (RST) begin
      LIT_VALUE <= REG_RESET;
    end else begin
      LIT_VALUE <= LIT_VALID ? lit_d : LIT_VALUE;
    end
  end

  // Software must not read through stack pointer right after limit write
  assign SP_OUT = sp_val; // RQ9
  assign LIMIT_OUT = limit_q;
endmodule
`default_nettype wire

// ===== hdl/slea_regfile.sv
// Working register file with registered read ports a and b and an unregistered stack pointer port
`timescale 1ns/10ps
`default_nettype none
module slea_regfile (
  input wire logic clk,
  input wire logic rst,
  input wire logic [slea_pkg::REG_IDX_W-1:0] ra_idx,
  input wire logic [slea_pkg::REG_IDX_W-1:0] rb_idx,
  output logic [slea_pkg::WORD_W-1:0] ra_data,
  output logic [slea_pkg::WORD_W-1:0] rb_data,
  output logic [slea_pkg::WORD_W-1:0] sp_data,
  input wire logic wa_en,
  input wire logic [slea_pkg::REG_IDX_W-1:0] wa_idx,
  input wire logic [slea_pkg::WORD_W-1:0] wa_data,
  input wire logic wb_en,
  input wire logic [slea_pkg::REG_IDX_W-1:0] wb_idx,
  input wire logic [slea_pkg::WORD_W-1:0] wb_data
);
  import slea_pkg::*;
  logic [WORD_W-1:0] mem_q [NREG];
  // Port b wins when both write one register
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < NREG; i++) begin
        mem_q[i] <= REG_RESET;
      end
    end else begin
      if (wa_en) begin
        mem_q[wa_idx] <= wa_data;
      end
      if (wb_en) begin
        mem_q[wb_idx] <= wb_data;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      ra_data <= REG_RESET;
      rb_data <= REG_RESET;
    end else begin
      ra_data <= mem_q[ra_idx];
      rb_data <= mem_q[rb_idx];
    end
  end
  assign sp_data = mem_q[SP_IDX];
endmodule
`default_nettype wire

// ===== pkg/slea_pkg.sv
// Package: constants and types for stack check and address generation
package slea_pkg;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned NREG = 16;
  localparam int unsigned REG_IDX_W = 4;
  localparam int unsigned FILE_ADDR_W = 13;
  localparam logic [15:0] SP_FLOOR = 16'h0800;
  localparam int unsigned SP_IDX = 15;
  localparam int unsigned DEFAULT_WORKING_REG_IDX = 0;
  localparam logic [15:0] WORD_STEP = 16'h0002;
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam int unsigned LIT5_W = 5;
  localparam int unsigned LIT8_W = 8;
  localparam int unsigned LIT10_W = 10;
  localparam int unsigned LIT14_W = 14;
  typedef enum logic [3:0] {
    SLEA_AM_FILE,
    SLEA_AM_DIRECT,
    SLEA_AM_IND,
    SLEA_AM_IND_POST,
    SLEA_AM_IND_PRE,
    SLEA_AM_INDEXED,
    SLEA_AM_LIT_OFS,
    SLEA_AM_PUSH,
    SLEA_AM_POP,
    SLEA_AM_CALL_PUSH,
    SLEA_AM_EXC_PUSH
  } slea_mode_t;
  typedef enum logic [2:0] {
    SLEA_LIT_5,
    SLEA_LIT_8,
    SLEA_LIT_10,
    SLEA_LIT_14,
    SLEA_LIT_16S
  } slea_lit_t;
  typedef enum logic [1:0] {
    SLEA_SEG_NORMAL,
    SLEA_SEG_BOOT,
    SLEA_SEG_SECURE
  } slea_seg_t;
endpackage

// ===== verif/slea_core_properties.sv
// Concurrent checks on the stack and address ports
`timescale 1ns/10ps
`default_nettype none
module slea_core_properties (
  input wire logic CLK,
  input wire logic RST,
  input wire logic REQ_VALID,
  input wire slea_pkg::slea_mode_t MODE,
  input wire logic [7:0] PC_HIGH,
  input wire logic [7:0] STATUS_LOW,
  input wire logic LIMIT_WR,
  input wire logic [15:0] LIMIT_DATA,
  input wire logic EA_VALID,
  input wire logic [15:0] EA,
  input wire logic [15:0] PUSH_DATA,
  input wire logic PUSH_DATA_VALID,
  input wire logic ACCESS_BLOCKED,
  input wire logic STACK_TRAP,
  input wire logic STACK_UNDERFLOW,
  input wire logic [15:0] SP_OUT,
  input wire logic [15:0] LIMIT_OUT
);
  import slea_pkg::*;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);
  logic psh;
  logic pop;
  assign psh = REQ_VALID && MODE == SLEA_AM_PUSH;
  assign pop = REQ_VALID && MODE == SLEA_AM_POP;
  AST_LIMIT_ALIGN: assert property (
    LIMIT_WR |=> LIMIT_OUT == ($past(LIMIT_DATA) & 16'hfffe)) else $error("limit odd");
  AST_PUSH_EA: assert property (
    psh |=> EA_VALID && EA == $past(SP_OUT)) else $error("push address");
  AST_PUSH_INC: assert property (
    psh |=> SP_OUT == $past(SP_OUT) + WORD_STEP) else $error("push step");
  AST_POP_EA: assert property (
    pop |=> EA == $past(SP_OUT) - WORD_STEP && SP_OUT == EA) else $error("pop address");
  AST_CALL_DATA: assert property (
    REQ_VALID && MODE == SLEA_AM_CALL_PUSH |=> PUSH_DATA_VALID && PUSH_DATA == {8'h00,
    $past(PC_HIGH)}) else $error("call data");
  AST_EXC_DATA: assert property (
    REQ_VALID && MODE == SLEA_AM_EXC_PUSH |=> PUSH_DATA == {$past(STATUS_LOW),
    $past(PC_HIGH)}) else $error("exception data");
  AST_OVER_TRAP: assert property (
    psh && SP_OUT > LIMIT_OUT |=> STACK_TRAP) else $error("no overflow trap");
  AST_AT_LIMIT: assert property (
    psh && SP_OUT == LIMIT_OUT && SP_OUT >= SP_FLOOR |=> !STACK_TRAP) else $error("early trap");
  AST_UNDER: assert property (
    psh && SP_OUT < SP_FLOOR |=> STACK_UNDERFLOW && STACK_TRAP) else $error("no underflow");
  AST_TRAP_CAUSE: assert property (
    STACK_TRAP |-> $past(REQ_VALID)) else $error("trap without request");
  C_AT_LIMIT: cover property (psh && SP_OUT == LIMIT_OUT);
  C_UNDER: cover property (STACK_UNDERFLOW);
  C_BLOCK: cover property (ACCESS_BLOCKED);
endmodule
bind slea_core slea_core_properties slea_core_properties_inst (.*);
`default_nettype wire

// ===== verif/slea_core_tb.sv
// Self-checking bench for stack checks and address forming
`timescale 1ns/10ps
`default_nettype none
module slea_core_tb;
  import slea_pkg::*;
  logic CLK, RST, REQ_VALID, IS_MOVE, DEST_TO_DEFAULT_WORKING_REG, LIT_VALID, LIMIT_WR, REG_WR;
  logic BOOT_RAM_EN, SEC_RAM_EN, EA_VALID, PUSH_DATA_VALID, ACCESS_BLOCKED;
  logic STACK_TRAP, STACK_UNDERFLOW;
  logic [3:0] PTR_IDX, OFS_IDX, REG_WR_IDX, WB_IDX;
  logic [12:0] FILE_ADDR;
  logic [7:0] PC_HIGH, STATUS_LOW, n_trap, n_under;
  logic [15:0] FULL_ADDR, MOD_CONST, LIT_OFS, PC_LOW, LIT_FIELD, LIMIT_DATA, REG_WR_DATA;
  logic [15:0] BOOT_RAM_LO, BOOT_RAM_HI, SEC_RAM_LO, SEC_RAM_HI, EA, PUSH_DATA;
  logic [15:0] LIT_VALUE, SP_OUT, LIMIT_OUT;
  slea_mode_t MODE;
  slea_lit_t LIT_KIND;
  slea_seg_t EXEC_SEG;
  int n_errors = 0;
  int cmp_count = 0;
  slea_core slea_core_inst (.*);
  slea_exc_model slea_exc_model_inst (.clk(CLK), .rst(RST), .trap(STACK_TRAP),
    .underflow(STACK_UNDERFLOW), .n_trap_q(n_trap), .n_under_q(n_under));
  always #10 CLK = ~CLK;
  task chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Answer is looked at once the taking edge has landed
  task req(input slea_mode_t m);
    @(posedge CLK);
    REQ_VALID <= 1'b1;
    MODE <= m;
    @(posedge CLK);
    REQ_VALID <= 1'b0;
    #1;
  endtask
  task wr(input logic lim, input logic [3:0] idx, input logic [15:0] d);
    @(posedge CLK);
    LIMIT_WR <= lim;
    REG_WR <= !lim;
    REG_WR_IDX <= idx;
    REG_WR_DATA <= d;
    LIMIT_DATA <= d;
    @(posedge CLK);
    {LIMIT_WR, REG_WR} <= 2'b00;
    #1;
  endtask
  task t_stack;
    wr(1'b1, 4'h0, 16'h1fff);
    chk(LIMIT_OUT, 16'h1ffe);
    wr(1'b0, 4'hf, 16'h1ffc);
    for (int i = 0; i < 3; i++) begin
      req(SLEA_AM_PUSH);
      chk(EA, 16'h1ffc + 16'(2 * i));
      chk(STACK_TRAP, i == 2);
      chk(SP_OUT, 16'h1ffe + 16'(2 * i));
    end
    req(SLEA_AM_POP);
    chk(EA, 16'h2000);
    chk(SP_OUT, 16'h2000);
  endtask
  task automatic t_push_data;
    slea_mode_t m [3] = '{SLEA_AM_PUSH, SLEA_AM_CALL_PUSH, SLEA_AM_EXC_PUSH};
    logic [15:0] e [3] = '{16'h1234, 16'h005a, 16'hc35a};
    wr(1'b1, 4'h0, 16'h3ffe);
    @(posedge CLK);
    PC_LOW <= 16'h1234;
    PC_HIGH <= 8'h5a;
    STATUS_LOW <= 8'hc3;
    foreach (m[i]) begin
      req(m[i]);
      chk(PUSH_DATA, e[i]);
      chk(PUSH_DATA_VALID, 1'b1);
    end
  endtask
  task t_underflow;
    wr(1'b0, 4'hf, 16'h07fe);
    req(SLEA_AM_PUSH);
    chk({STACK_UNDERFLOW, STACK_TRAP}, 2'b11);
    req(SLEA_AM_PUSH);
    chk({STACK_UNDERFLOW, STACK_TRAP}, 2'b00);
  endtask
  // Post-modify feeds the later pre-modify, whose pointer write feeds the offset sums
  task automatic t_addr;
    slea_mode_t m [7] = '{SLEA_AM_DIRECT, SLEA_AM_IND, SLEA_AM_IND_POST, SLEA_AM_IND_PRE,
      SLEA_AM_INDEXED, SLEA_AM_LIT_OFS, SLEA_AM_FILE};
    logic [15:0] e [7] = '{16'h0400, 16'h0400, 16'h0400, 16'h03fc, 16'h041c, 16'h040c,
      16'h1fff};
    wr(1'b0, 4'h3, 16'h0400);
    wr(1'b0, 4'h4, 16'h0020);
    @(posedge CLK);
    PTR_IDX <= 4'h3;
    OFS_IDX <= 4'h4;
    MOD_CONST <= 16'hfffe;
    LIT_OFS <= 16'h0010;
    FILE_ADDR <= 13'h1fff;
    DEST_TO_DEFAULT_WORKING_REG <= 1'b1;
    foreach (m[i]) begin
      req(m[i]);
      chk(EA, e[i]);
    end
    chk(WB_IDX, 4'h0);
    @(posedge CLK);
    IS_MOVE <= 1'b1;
    DEST_TO_DEFAULT_WORKING_REG <= 1'b0;
    FULL_ADDR <= 16'hfffe;
    req(SLEA_AM_FILE);
    chk(EA, 16'hfffe);
    chk(WB_IDX, 4'h3);
  endtask
  task automatic t_secure;
    slea_seg_t s [5] = '{SLEA_SEG_NORMAL, SLEA_SEG_BOOT, SLEA_SEG_BOOT, SLEA_SEG_SECURE,
      SLEA_SEG_SECURE};
    logic [15:0] a [5] = '{16'h1010, 16'h10ff, 16'h1100, 16'h11ff, 16'h10ff};
    logic b [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
    foreach (s[i]) begin
      @(posedge CLK);
      BOOT_RAM_EN <= 1'b1;
      SEC_RAM_EN <= 1'b1;
      EXEC_SEG <= s[i];
      FULL_ADDR <= a[i];
      req(SLEA_AM_FILE);
      chk({ACCESS_BLOCKED, EA_VALID}, {b[i], !b[i]});
    end
  endtask
  task automatic t_lit;
    slea_lit_t k [5] = '{SLEA_LIT_5, SLEA_LIT_8, SLEA_LIT_10, SLEA_LIT_14, SLEA_LIT_16S};
    logic [15:0] e [5] = '{16'h001f, 16'h00ff, 16'h03ff, 16'h3fff, 16'hffff};
    foreach (k[i]) begin
      @(posedge CLK);
      LIT_VALID <= 1'b1;
      LIT_KIND <= k[i];
      LIT_FIELD <= 16'hffff;
      @(posedge CLK);
      LIT_VALID <= 1'b0;
      #1;
      chk(LIT_VALUE, e[i]);
    end
  endtask
  task complete_run;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge CLK);
    n_errors++;
    complete_run;
  end
  initial begin
    {CLK, REQ_VALID, IS_MOVE, DEST_TO_DEFAULT_WORKING_REG, LIT_VALID, LIMIT_WR, REG_WR} = '0;
    {BOOT_RAM_EN, SEC_RAM_EN, PTR_IDX, OFS_IDX, REG_WR_IDX, FILE_ADDR} = '0;
    {PC_HIGH, STATUS_LOW, FULL_ADDR, MOD_CONST, LIT_OFS, PC_LOW, LIT_FIELD} = '0;
    {LIMIT_DATA, REG_WR_DATA} = '0;
    {BOOT_RAM_LO, BOOT_RAM_HI, SEC_RAM_LO, SEC_RAM_HI} = 64'h1000_10ff_1100_11ff;
    MODE = SLEA_AM_FILE;
    LIT_KIND = SLEA_LIT_5;
    EXEC_SEG = SLEA_SEG_NORMAL;
    RST = 1'b1;
    repeat (12) @(posedge CLK);
    RST <= 1'b0;
    t_stack;
    t_push_data;
    t_underflow;
    t_addr;
    t_secure;
    t_lit;
    chk({n_trap, n_under}, 16'h0201);
    complete_run;
  end
endmodule
`default_nettype wire

// ===== verif/slea_exc_model.sv
// Exception logic model that counts stack trap requests
`timescale 1ns/10ps
`default_nettype none
module slea_exc_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic trap,
  input wire logic underflow,
  output logic [7:0] n_trap_q,
  output logic [7:0] n_under_q
);
  // One count per cycle, so a stuck level overcounts
  always_ff @(posedge clk) begin
    if (rst) begin
      n_trap_q <= 8'h00;
      n_under_q <= 8'h00;
    end else begin
      n_trap_q <= n_trap_q + {7'h00, trap};
      n_under_q <= n_under_q + {7'h00, underflow};
    end
  end
endmodule
`default_nettype wire
